/* File: phy_basic_control_regs.sv */
// Behaviour
// - PHY registers reached only through indexed management access, not memory mapped.
// - Indexes 0-6, 17, 18, 27, 29, 30, 31 select the PHY registers.
// - Retained fields survive only the soft reset from control bit 15.
// - Bit 15 write 1 starts soft reset; self-clears when done; reads 1 while the reset runs.
// - Bit 14 loopback when 1; reset 0.
// - Bit 13 speed 100 when 1; reset 1; ignored while autoneg enabled.
// - Bit 12 autoneg enable, reset 1; overrides speed and duplex.
// - Bit 11 general power-down when 1; reset 0.
// - Bit 9 write 1 restarts autoneg, self-clears; writing 0 no effect.
// - Bit 8 full duplex when 1; reset 0; ignored while autoneg enabled.
module phy_basic_control_regs
  import phy_ctrl_pkg::*;
#(
  parameter int RESET_CYCLES = SOFT_RESET_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [4:0]  mgmt_index,
  input  wire logic        mgmt_wr,
  input  wire logic        mgmt_rd,
  input  wire logic [15:0] mgmt_wdata,
  input  wire logic [15:0] other_rdata,
  output logic      [15:0] mgmt_rdata,
  output logic             mgmt_rvalid,
  output logic      [4:0]  other_sel,
  output logic             soft_reset,
  output logic             loopback,
  output logic             power_down,
  output logic             collision_test,
  output logic             an_enable,
  output logic             an_restart,
  output logic             speed_100,
  output logic             full_duplex,
  input  wire logic        an_done,
  input  wire logic        an_speed_100,
  input  wire logic        an_full_duplex
);

  // ==========================================================
  // Register state
  localparam int CW = $clog2(RESET_CYCLES + 1);

  logic          loopback_ff;
  logic          speed_ff;
  logic          an_enable_ff;
  logic          power_down_ff;
  logic          duplex_ff;
  logic          col_test_ff;
  logic          an_restart_ff;
  logic [CW-1:0] srst_cnt_ff;
  logic          srst_busy_ff;
  logic [15:0]   rdata_ff;
  logic          rvalid_ff;
  logic [4:0]    other_sel_ff;
  logic          speed_out_ff;
  logic          duplex_out_ff;
  reg_sel_e      sel;
  logic          ctrl_wr;
  logic          srst_req;
  logic [15:0]   ctrl_view;
  logic          field_wr;
  logic          nxt_loopback;
  logic          nxt_speed;
  logic          nxt_an_enable;
  logic          nxt_power_down;
  logic          nxt_duplex;
  logic          nxt_col_test;

  phy_index_decode u_decode (
    .index (mgmt_index),
    .sel   (sel)
  );

  // Only index 0 is held here; others are forwarded by index
  assign ctrl_wr  = mgmt_wr && (sel == SEL_CONTROL);
  assign srst_req = ctrl_wr && mgmt_wdata[BIT_SOFT_RESET];
  assign field_wr = ctrl_wr && !srst_busy_ff;

  // ==========================================================
  // Soft reset sequencer
  // Busy flag doubles as the readable bit 15 until the count ends
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      srst_busy_ff <= 1'b0;
      srst_cnt_ff  <= '0;
    end else if (srst_req && !srst_busy_ff) begin
      srst_busy_ff <= 1'b1;
      srst_cnt_ff  <= CW'(RESET_CYCLES - 1);
    end else if (srst_busy_ff) begin
      if (srst_cnt_ff == '0) begin
        srst_busy_ff <= 1'b0;
      end else begin
        srst_cnt_ff <= srst_cnt_ff - CW'(1);
      end
    end
  end

  // ==========================================================
  // Writable control fields: loopback, bit 14
  // Soft reset restores defaults; no field here is retained across it,
  // so the retained marking only matters for the other registers
  always_comb begin
    nxt_loopback = loopback_ff;
    if (srst_req) begin
      nxt_loopback = RST_LOOPBACK;
    end else if (field_wr) begin
      nxt_loopback = mgmt_wdata[BIT_LOOPBACK];
    end
  end

  // Loopback register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      loopback_ff <= RST_LOOPBACK;
    end else begin
      loopback_ff <= nxt_loopback;
    end
  end

  // ==========================================================
  // Manual speed, bit 13
  // Stored even while negotiation runs; only the output mux ignores it
  always_comb begin
    nxt_speed = speed_ff;
    if (srst_req) begin
      nxt_speed = RST_SPEED;
    end else if (field_wr) begin
      nxt_speed = mgmt_wdata[BIT_SPEED];
    end
  end

  // Manual speed register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      speed_ff <= RST_SPEED;
    end else begin
      speed_ff <= nxt_speed;
    end
  end

  // ==========================================================
  // Auto-negotiation enable, bit 12
  // Defaults on, so a soft reset hands speed back to the negotiator
  always_comb begin
    nxt_an_enable = an_enable_ff;
    if (srst_req) begin
      nxt_an_enable = RST_AN_ENABLE;
    end else if (field_wr) begin
      nxt_an_enable = mgmt_wdata[BIT_AN_ENABLE];
    end
  end

  // Auto-negotiation enable register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      an_enable_ff <= RST_AN_ENABLE;
    end else begin
      an_enable_ff <= nxt_an_enable;
    end
  end

  // ==========================================================
  // General power-down, bit 11
  // Host should drop negotiation first; the bit itself does not check
  always_comb begin
    nxt_power_down = power_down_ff;
    if (srst_req) begin
      nxt_power_down = RST_POWER_DOWN;
    end else if (field_wr) begin
      nxt_power_down = mgmt_wdata[BIT_POWER_DOWN];
    end
  end

  // Power-down register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      power_down_ff <= RST_POWER_DOWN;
    end else begin
      power_down_ff <= nxt_power_down;
    end
  end

  // ==========================================================
  // Manual duplex, bit 8
  // Stored in manual form; negotiated duplex is picked downstream
  always_comb begin
    nxt_duplex = duplex_ff;
    if (srst_req) begin
      nxt_duplex = RST_DUPLEX;
    end else if (field_wr) begin
      nxt_duplex = mgmt_wdata[BIT_DUPLEX];
    end
  end

  // Manual duplex register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      duplex_ff <= RST_DUPLEX;
    end else begin
      duplex_ff <= nxt_duplex;
    end
  end

  // ==========================================================
  // Collision test, bit 7
  // Busy writes are dropped so a stray write cannot undo the reset
  always_comb begin
    nxt_col_test = col_test_ff;
    if (srst_req) begin
      nxt_col_test = RST_COL_TEST;
    end else if (field_wr) begin
      nxt_col_test = mgmt_wdata[BIT_COL_TEST];
    end
  end

  // Collision test register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      col_test_ff <= RST_COL_TEST;
    end else begin
      col_test_ff <= nxt_col_test;
    end
  end

  // ==========================================================
  // Restart request: held until the negotiator reports done
  always_ff @(posedge clk) begin
    if (!rst_n || srst_req) begin
      an_restart_ff <= 1'b0;
    end else if (ctrl_wr && !srst_busy_ff && mgmt_wdata[BIT_AN_RESTART]) begin
      an_restart_ff <= 1'b1;
    end else if (an_done) begin
      an_restart_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Effective speed and duplex
  // Negotiated result wins while auto-negotiation is on; the one cycle
  // of lag is the price of driving both outputs from flip-flops
  // Speed output
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      speed_out_ff <= RST_SPEED;
    end else begin
      speed_out_ff <= an_enable_ff ? an_speed_100 : speed_ff;
    end
  end

  // Duplex output
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      duplex_out_ff <= RST_DUPLEX;
    end else begin
      duplex_out_ff <= an_enable_ff ? an_full_duplex : duplex_ff;
    end
  end

  // ==========================================================
  // Read view of index 0, reserved bits zero
  always_comb begin
    ctrl_view                 = 16'h0000;
    ctrl_view[BIT_SOFT_RESET] = srst_busy_ff;
    ctrl_view[BIT_LOOPBACK]   = loopback_ff;
    ctrl_view[BIT_SPEED]      = speed_ff;
    ctrl_view[BIT_AN_ENABLE]  = an_enable_ff;
    ctrl_view[BIT_POWER_DOWN] = power_down_ff;
    ctrl_view[BIT_AN_RESTART] = an_restart_ff;
    ctrl_view[BIT_DUPLEX]     = duplex_ff;
    ctrl_view[BIT_COL_TEST]   = col_test_ff;
  end

  // ==========================================================
  // Read port, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_ff     <= 16'h0000;
      rvalid_ff    <= 1'b0;
      other_sel_ff <= 5'h00;
    end else begin
      rvalid_ff    <= mgmt_rd;
      other_sel_ff <= mgmt_index;
      if (mgmt_rd) begin
        case (sel)
          SEL_CONTROL: rdata_ff <= ctrl_view;
          SEL_NONE:    rdata_ff <= 16'h0000;
          default:     rdata_ff <= other_rdata;
        endcase
      end
    end
  end

  // ==========================================================
  // Outputs, all from flip-flops
  assign mgmt_rdata     = rdata_ff;
  assign mgmt_rvalid    = rvalid_ff;
  assign other_sel      = other_sel_ff;
  assign soft_reset     = srst_busy_ff;
  assign loopback       = loopback_ff;
  assign power_down     = power_down_ff;
  assign collision_test = col_test_ff;
  assign an_enable      = an_enable_ff;
  assign an_restart     = an_restart_ff;
  assign speed_100      = speed_out_ff;
  assign full_duplex    = duplex_out_ff;

endmodule : phy_basic_control_regs

/* File: phy_ctrl_checker.sv */
module phy_ctrl_checker #(
  parameter int RESET_CYCLES = 16
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [4:0]  mgmt_index,
  input wire logic        mgmt_wr,
  input wire logic        mgmt_rd,
  input wire logic [15:0] mgmt_wdata,
  input wire logic [15:0] other_rdata,
  input wire logic [15:0] mgmt_rdata,
  input wire logic        mgmt_rvalid,
  input wire logic        soft_reset,
  input wire logic        loopback,
  input wire logic        power_down,
  input wire logic        collision_test,
  input wire logic        an_enable,
  input wire logic        an_restart,
  input wire logic        speed_100,
  input wire logic        full_duplex,
  input wire logic        an_done,
  input wire logic        an_speed_100,
  input wire logic        an_full_duplex
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Control writes only count when no soft reset is running
  wire w0 = mgmt_wr && mgmt_index == 5'h00 && !soft_reset;
  logic [7:0] hi_ff;
  function automatic logic mapped(logic [4:0] i);
    return i <= 5'h06 || i inside {5'h11, 5'h12, 5'h1b, 5'h1d, 5'h1e, 5'h1f};
  endfunction : mapped
  // Counts busy cycles; a repetition cannot take the parameter
  always_ff @(posedge clk) begin
    if (!rst_n) hi_ff <= 8'h00;
    else hi_ff <= soft_reset ? hi_ff + 8'h01 : 8'h00;
  end
  // ==========================================================
  // Checks
  rd_answer_a: assert property (mgmt_rd |=> mgmt_rvalid) else $error("no read answer");
  rd_decode_a: assert property (mgmt_rd && mgmt_index != 5'h00 |=>
    mgmt_rdata == (mapped($past(mgmt_index)) ? $past(other_rdata) : 16'h0000))
    else $error("bad decode");
  rd_view_a: assert property (mgmt_rd && mgmt_index == 5'h00 |=>
    mgmt_rdata[10] == 1'b0 && mgmt_rdata[6:0] == 7'h00 &&
    mgmt_rdata[12:11] == $past({an_enable, power_down}))
    else $error("bad control view");
  rst_start_a: assert property (w0 && mgmt_wdata[15] |=> soft_reset && an_enable &&
    !loopback && !power_down && !collision_test) else $error("soft reset start");
  rst_len_a: assert property ($fell(soft_reset) |-> hi_ff == RESET_CYCLES)
    else $error("soft reset length");
  field_wr_a: assert property (w0 && !mgmt_wdata[15] |=>
    {loopback, an_enable, power_down, collision_test} ==
    $past({mgmt_wdata[14], mgmt_wdata[12:11], mgmt_wdata[7]})) else $error("field write");
  manual_mode_a: assert property (w0 && !mgmt_wdata[15] && !mgmt_wdata[12]
    ##1 !mgmt_wr |=> {speed_100, full_duplex} == $past({mgmt_wdata[13], mgmt_wdata[8]}, 2))
    else $error("manual mode");
  // Reset term keeps the release edge, where the output is still a reset value, out
  an_mode_a: assert property (rst_n && an_enable |=>
    {speed_100, full_duplex} == $past({an_speed_100, an_full_duplex}))
    else $error("negotiated mode");
  restart_set_a: assert property (w0 && mgmt_wdata[9] && !mgmt_wdata[15] |=> an_restart)
    else $error("restart set");
  restart_clr_a: assert property (an_restart && an_done && !mgmt_wr |=> !an_restart)
    else $error("restart clear");
  cover property ($fell(soft_reset));
  cover property (an_restart && an_done);
  cover property (mgmt_rd && mgmt_index == 5'h1f);
endmodule : phy_ctrl_checker

bind phy_basic_control_regs phy_ctrl_checker #(.RESET_CYCLES(RESET_CYCLES)) i_chk (
  .clk(clk), .rst_n(rst_n), .mgmt_index(mgmt_index), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
  .mgmt_wdata(mgmt_wdata), .other_rdata(other_rdata), .mgmt_rdata(mgmt_rdata),
  .mgmt_rvalid(mgmt_rvalid), .soft_reset(soft_reset), .loopback(loopback),
  .power_down(power_down), .collision_test(collision_test), .an_enable(an_enable),
  .an_restart(an_restart), .speed_100(speed_100), .full_duplex(full_duplex),
  .an_done(an_done), .an_speed_100(an_speed_100), .an_full_duplex(an_full_duplex));

/* File: phy_ctrl_pkg.sv */
package phy_ctrl_pkg;

  // ==========================================================
  // Register indexes
  localparam logic [4:0] IDX_BASIC_CONTROL = 5'h00;
  localparam logic [4:0] IDX_BASIC_STATUS  = 5'h01;
  localparam logic [4:0] IDX_ID1           = 5'h02;
  localparam logic [4:0] IDX_ID2           = 5'h03;
  localparam logic [4:0] IDX_ADVERTISE     = 5'h04;
  localparam logic [4:0] IDX_PARTNER       = 5'h05;
  localparam logic [4:0] IDX_EXPANSION     = 5'h06;
  localparam logic [4:0] IDX_MODE_CTRL     = 5'h11;
  localparam logic [4:0] IDX_SPECIAL_MODES = 5'h12;
  localparam logic [4:0] IDX_INDICATION    = 5'h1b;
  localparam logic [4:0] IDX_INT_SOURCE    = 5'h1d;
  localparam logic [4:0] IDX_INT_MASK      = 5'h1e;
  localparam logic [4:0] IDX_SPECIAL_CTRL  = 5'h1f;

  // ==========================================================
  // Basic control bit positions
  localparam int BIT_SOFT_RESET = 15;
  localparam int BIT_LOOPBACK   = 14;
  localparam int BIT_SPEED      = 13;
  localparam int BIT_AN_ENABLE  = 12;
  localparam int BIT_POWER_DOWN = 11;
  localparam int BIT_AN_RESTART = 9;
  localparam int BIT_DUPLEX     = 8;
  localparam int BIT_COL_TEST   = 7;

  // Reset values of the writable fields
  localparam logic RST_LOOPBACK   = 1'b0;
  localparam logic RST_SPEED      = 1'b1;
  localparam logic RST_AN_ENABLE  = 1'b1;
  localparam logic RST_POWER_DOWN = 1'b0;
  localparam logic RST_DUPLEX     = 1'b0;
  localparam logic RST_COL_TEST   = 1'b0;

  // Soft reset pulse length in clocks
  localparam int SOFT_RESET_CYCLES = 16;

  // Index decode result
  typedef enum logic [3:0] {
    SEL_NONE, SEL_CONTROL, SEL_STATUS, SEL_ID1, SEL_ID2, SEL_ADV, SEL_PARTNER,
    SEL_EXP, SEL_MODE, SEL_SPECIAL, SEL_IND, SEL_ISRC, SEL_IMASK, SEL_SCTRL
  } reg_sel_e;

endpackage : phy_ctrl_pkg

/* File: phy_far_model.sv */
module phy_far_model (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        slow,
  input wire logic [1:0]  neg,
  input wire logic [4:0]  other_sel,
  input wire logic        an_restart,
  output logic     [15:0] other_rdata,
  output logic            an_done,
  output logic            an_speed_100,
  output logic            an_full_duplex
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] cnt_ff;
  // Every index answers, so an unmapped read that leaks shows up
  assign other_rdata = {~other_sel, 11'h2c5};
  assign {an_speed_100, an_full_duplex} = neg;
  assign an_done = cnt_ff == (slow ? 5'h14 : 5'h02);
  // Negotiation finishes a few or many cycles after a restart
  always_ff @(posedge clk) begin
    if (!rst_n || !an_restart) cnt_ff <= 5'h00;
    else if (!an_done) cnt_ff <= cnt_ff + 5'h01;
  end
endmodule : phy_far_model

/* File: phy_index_decode.sv */
module phy_index_decode
  import phy_ctrl_pkg::*;
(
  input  wire logic [4:0] index,
  output reg_sel_e        sel
);

  // ==========================================================
  // Index to register select
  always_comb begin
    case (index)
      IDX_BASIC_CONTROL: sel = SEL_CONTROL;
      IDX_BASIC_STATUS:  sel = SEL_STATUS;
      IDX_ID1:           sel = SEL_ID1;
      IDX_ID2:           sel = SEL_ID2;
      IDX_ADVERTISE:     sel = SEL_ADV;
      IDX_PARTNER:       sel = SEL_PARTNER;
      IDX_EXPANSION:     sel = SEL_EXP;
      IDX_MODE_CTRL:     sel = SEL_MODE;
      IDX_SPECIAL_MODES: sel = SEL_SPECIAL;
      IDX_INDICATION:    sel = SEL_IND;
      IDX_INT_SOURCE:    sel = SEL_ISRC;
      IDX_INT_MASK:      sel = SEL_IMASK;
      IDX_SPECIAL_CTRL:  sel = SEL_SCTRL;
      default:           sel = SEL_NONE;
    endcase
  end

endmodule : phy_index_decode

/* File: tb_phy_basic_control_regs.sv */
module tb_phy_basic_control_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, mgmt_wr = 0, mgmt_rd = 0, slow = 0;
  logic [4:0] mgmt_index = 0, other_sel;
  logic [15:0] mgmt_wdata = 0, other_rdata, mgmt_rdata, w;
  logic [1:0] neg = 0;
  logic mgmt_rvalid, soft_reset, loopback, power_down, collision_test, an_enable;
  logic an_restart, speed_100, full_duplex, an_done, an_speed_100, an_full_duplex;
  logic [15:0] exp_q[$];
  int err_count = 0, n_compared = 0;
  always #20 clk = ~clk;
  phy_basic_control_regs #(.RESET_CYCLES(4)) i_dut (.clk(clk), .rst_n(rst_n),
    .mgmt_index(mgmt_index), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata),
    .other_rdata(other_rdata), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
    .other_sel(other_sel), .soft_reset(soft_reset), .loopback(loopback),
    .power_down(power_down), .collision_test(collision_test), .an_enable(an_enable),
    .an_restart(an_restart), .speed_100(speed_100), .full_duplex(full_duplex),
    .an_done(an_done), .an_speed_100(an_speed_100), .an_full_duplex(an_full_duplex));
  phy_far_model i_far (.clk(clk), .rst_n(rst_n), .slow(slow), .neg(neg),
    .other_sel(other_sel), .an_restart(an_restart), .other_rdata(other_rdata),
    .an_done(an_done), .an_speed_100(an_speed_100), .an_full_duplex(an_full_duplex));
  // ==========================================================
  // Tasks
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      $display("MISMATCH %s exp %h got %h", n, e, s);
      err_count++;
    end
  endtask : chk
  task automatic close_out();
    $display("errors %0d compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic wr(logic [4:0] i, logic [15:0] d);
    @(posedge clk);
    mgmt_index <= i;
    mgmt_wdata <= d;
    mgmt_wr <= 1'b1;
    @(posedge clk);
    mgmt_wr <= 1'b0;
    @(negedge clk);
  endtask : wr
  // Index goes out a cycle early: the far side decodes the registered copy
  task automatic rd(logic [4:0] i, logic [15:0] e);
    @(posedge clk);
    mgmt_index <= i;
    @(posedge clk);
    mgmt_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    mgmt_rd <= 1'b0;
  endtask : rd
  task automatic wait_low(ref logic s);
    for (int k = 0; k < 60 && s !== 1'b0; k++) @(negedge clk);
    if (s !== 1'b0) begin
      err_count++;
      close_out();
    end
  endtask : wait_low
  // Result watcher takes the oldest note
  always @(posedge clk) begin
    if (mgmt_rvalid === 1'b1) chk("rdata", exp_q.pop_front(), mgmt_rdata);
  end
  // ==========================================================
  // Sequence
  initial begin
    void'($urandom(83154));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(5'h00, 16'h3000);
    for (int i = 1; i < 32; i++) begin
      rd(i[4:0], (i <= 6 || i inside {17, 18, 27, 29, 30, 31}) ?
        {~i[4:0], 11'h2c5} : 16'h0000);
    end
    for (int i = 0; i < 6; i++) begin
      w = (i == 0) ? 16'h7dff : 16'($urandom) & 16'h7dff;
      w[12] = w[12] & ~w[11];
      @(posedge clk);
      neg <= 2'($urandom);
      wr(5'h00, w);
      chk("ctl", {w[14], w[12:11], w[7], 1'b0},
        {loopback, an_enable, power_down, collision_test, an_restart});
      @(negedge clk);
      chk("mode", w[12] ? neg : {w[13], w[8]}, {speed_100, full_duplex});
      rd(5'h00, w & 16'h7980);
    end
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      slow <= s[0];
      wr(5'h00, 16'h1200);
      chk("restart", 16'h0001, 16'(an_restart));
      wait_low(an_restart);
    end
    // Busy write must be refused, so loopback stays at its default
    wr(5'h00, 16'h4980);
    wr(5'h00, 16'h8000);
    chk("busy", 16'h0001, 16'(soft_reset));
    wr(5'h00, 16'h4000);
    wait_low(soft_reset);
    rd(5'h00, 16'h3000);
    repeat (4) @(posedge clk);
    chk("drain", 16'h0000, 16'(exp_q.size()));
    close_out();
  end
endmodule : tb_phy_basic_control_regs
